// >>> core/adc_postproc_temp_channel.sv
/*
  Digital side of the measurement converter: temperature channel select,
  calibration, two-stage decimation with mains notch result, clock gates,
  sample averaging into the transform path, AXI4-Lite register slave.
  Assumes samples arrive synchronous to aclk, at most one per cycle.
*/
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module adc_postproc_temp_channel
  import adc_postproc_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [15:0] awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [15:0] araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire sample_t     sample_in,
  output word_t            transform_out,
  output logic             conv_start,
  output logic             conv_active,
  output logic             temp_sensor_power,
  output logic [2:0]       chop_mode,
  output logic             transform_clk_en,
  output logic             waveform_clk_en,
  output logic             mains_filter_clk_en
);

  state_t s_q;
  state_t s_d;

  logic [4:0]         wi;
  logic [4:0]         ri;
  logic [31:0]        wv;
  logic [31:0]        wmask;
  logic               temp_sel;
  logic               temp_pos;
  logic               conv_req;
  logic               notch_on;
  logic               avg_on;
  logic               transform_clock_gate_n;
  logic               waveform_clock_gate_n;
  logic               mains_filter_clock_gate_n;
  logic [1:0]         average_count;
  logic [1:0]         first_decimation_ratio;
  logic [3:0]         second_decimation_ratio;
  logic [15:0]        off_sel;
  logic [15:0]        gain_sel;
  logic signed [16:0] diff;
  logic signed [33:0] prod;
  logic [31:0]        s1_next;
  logic [31:0]        s2_next;
  logic [31:0]        av_next;
  logic               mains_write;

  // Field decode from the stored configuration
  always_comb
  begin
    transform_clock_gate_n    = s_q.rf[I_FILT][XF_GATE];
    waveform_clock_gate_n     = s_q.rf[I_FILT][WAVE_GATE];
    mains_filter_clock_gate_n = s_q.rf[I_FILT][MAINS_GATE];
    average_count             = s_q.rf[I_FILT][AVG_LSB +: 2];
    first_decimation_ratio    = s_q.rf[I_FILT][R1_LSB +: 2];
    second_decimation_ratio   = s_q.rf[I_FILT][R2_LSB +: 4];
    temp_pos = s_q.rf[I_ACON][5:0] == POS_TEMP;
    temp_sel = temp_pos && s_q.rf[I_ACON][NEG_LSB +: 5] == NEG_TEMP;
    conv_req = s_q.rf[I_AFE][AFE_CONV] && s_q.rf[I_AFE][AFE_ADC];
    notch_on = !s_q.rf[I_FILT][NOTCH_OFF] && s_q.rf[I_AFE][AFE_NOTCH];
    avg_on   = s_q.rf[I_PCTL][AVG_EN];
  end

  // Offset and gain correction; temp channel uses its own pair
  always_comb
  begin
    off_sel  = temp_pos ? s_q.rf[I_TOFF][15:0] : s_q.rf[I_COFF][15:0];
    gain_sel = temp_pos ? s_q.rf[I_TGAIN][15:0] : s_q.rf[I_CGAIN][15:0];
    diff = $signed({1'b0, sample_in.code}) - $signed({off_sel[15], off_sel});
    prod = diff * $signed({1'b0, gain_sel});
  end

  // Accumulator sums for the decimation and averaging stages
  always_comb
  begin
    s1_next = s_q.s1_acc + s_q.cal.data;
    s2_next = s_q.s2_acc + s_q.s1_sum;
    av_next = s_q.av_acc + s_q.cal.data;
    mains_write = s_q.s1_done && !mains_filter_clock_gate_n && notch_on
                  && s_q.s2_cnt + 11'h001 == second_ratio(second_decimation_ratio);
  end

  // Next-state logic for the whole block
  always_comb
  begin
    s_d = s_q;
    wi = reg_index(s_q.waddr);
    ri = reg_index(araddr);
    wv = s_q.rf[wi];
    wmask = (wi == I_FILT) ? MASK_FILT : ((wi == I_STAT) ? 32'h0000_0000 : 32'hFFFF_FFFF);
    s_d.conv_start = 1'b0;
    s_d.cal.valid = 1'b0;
    s_d.s1_done = 1'b0;
    s_d.xf.valid = 1'b0;

    // Write address and data taken in either order
    if (awvalid && s_q.awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.waddr = awaddr;
    end
    if (wvalid && s_q.wready)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (s_q.bvalid && bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (s_q.wstrb[b])
        begin
          wv[8*b +: 8] = s_q.wdata[8*b +: 8];
        end
      end
      if (wi != NO_REG)
      begin
        s_d.rf[wi] = (wv & wmask) | (s_q.rf[wi] & ~wmask);
      end
      s_d.bresp = (wi == NO_REG) ? RESP_DEC : RESP_OK;
      s_d.bvalid = 1'b1;
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;

    // Read channel, one outstanding read
    if (s_q.rvalid && rready)
    begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready)
    begin
      s_d.rdata = (ri == NO_REG) ? 32'h0000_0000 : s_q.rf[ri];
      s_d.rresp = (ri == NO_REG) ? RESP_DEC : RESP_OK;
      s_d.rvalid = 1'b1;
    end
    s_d.arready = !s_d.rvalid;

    // Conversion control and pin-level outputs
    s_d.conv_q = conv_req;
    s_d.conv_start = conv_req && !s_q.conv_q;
    s_d.temp_pwr = s_q.rf[I_AFE][AFE_TPWR];
    s_d.chop = s_q.rf[I_TCFG][CHOP_LSB +: 3];
    s_d.clk_en = ~s_q.rf[I_FILT][XF_GATE:MAINS_GATE];

    // Calibrated sample stage
    if (sample_in.valid && s_q.conv_q)
    begin
      s_d.cal.valid = 1'b1;
      s_d.cal.data = 32'(prod >>> CAL_SHIFT);
      s_d.cal_temp = temp_sel;
    end
    if (s_q.cal.valid)
    begin
      s_d.rf[I_RAW] = s_q.cal.data;
      if (s_q.cal_temp)
      begin
        s_d.rf[I_TEMP] = s_q.cal.data;
      end
    end

    // First decimation stage, frozen while its clock is gated
    if (s_q.cal.valid && !mains_filter_clock_gate_n)
    begin
      if (s_q.s1_cnt + 3'h1 >= first_ratio(first_decimation_ratio))
      begin
        s_d.s1_sum = s1_next;
        s_d.s1_done = 1'b1;
        s_d.s1_acc = 32'h0000_0000;
        s_d.s1_cnt = 3'h0;
      end
      else
      begin
        s_d.s1_acc = s1_next;
        s_d.s1_cnt = s_q.s1_cnt + 3'h1;
      end
    end

    // Second decimation stage sets the notch output rate
    if (s_q.s1_done && !mains_filter_clock_gate_n)
    begin
      if (s_q.s2_cnt + 11'h001 >= second_ratio(second_decimation_ratio))
      begin
        if (notch_on)
        begin
          s_d.rf[I_MAINS] = s2_next;
        end
        s_d.s2_acc = 32'h0000_0000;
        s_d.s2_cnt = 11'h000;
      end
      else
      begin
        s_d.s2_acc = s2_next;
        s_d.s2_cnt = s_q.s2_cnt + 11'h001;
      end
    end

    // Settling timer for the notch path
    if (!notch_on)
    begin
      s_d.settle = 24'h00_0000;
      s_d.settled = 1'b0;
    end
    else if (s_q.settle == 24'(SETTLE_CYCLES - 1))
    begin
      s_d.settled = 1'b1;
    end
    else
    begin
      s_d.settle = s_q.settle + 24'h00_0001;
    end

    // Averaging stage; output replaces the raw word at the transform input
    if (!avg_on)
    begin
      s_d.av_cnt = 5'h00;
      s_d.av_acc = 32'h0000_0000;
      if (s_q.cal.valid && !transform_clock_gate_n)
      begin
        s_d.xf.valid = 1'b1;
        s_d.xf.data = s_q.cal.data;
      end
    end
    else if (s_q.cal.valid)
    begin
      if (s_q.av_cnt + 5'h01 >= (5'h02 << average_count))
      begin
        s_d.xf.valid = !transform_clock_gate_n;
        s_d.xf.data = 32'($signed(av_next) >>> ({1'b0, average_count} + 3'h1)); // Three bits so code 3 shifts by 4
        s_d.av_cnt = 5'h00;
        s_d.av_acc = 32'h0000_0000;
      end
      else
      begin
        s_d.av_cnt = s_q.av_cnt + 5'h01;
        s_d.av_acc = av_next;
      end
    end

    // Read-only status word
    s_d.rf[I_STAT] = {28'h000_0000, temp_sel, notch_on, s_q.conv_q, s_q.settled};
  end

  // State register with synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.rf[I_FILT] <= RST_FILT;
      s_q.rf[I_DFTC] <= RST_DFTC;
      s_q.rf[I_REP] <= RST_REP;
      s_q.rf[I_BUF] <= RST_BUF;
      s_q.rf[I_TGAIN] <= RST_GAIN;
      s_q.rf[I_CGAIN] <= RST_GAIN;
      s_q.clk_en <= ~RST_FILT[XF_GATE:MAINS_GATE];
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign awready             = s_q.awready;
  assign wready              = s_q.wready;
  assign bvalid              = s_q.bvalid;
  assign bresp               = s_q.bresp;
  assign arready             = s_q.arready;
  assign rvalid              = s_q.rvalid;
  assign rdata               = s_q.rdata;
  assign rresp               = s_q.rresp;
  assign transform_out       = s_q.xf;
  assign conv_start          = s_q.conv_start;
  assign conv_active         = s_q.conv_q;
  assign temp_sensor_power   = s_q.temp_pwr;
  assign chop_mode           = s_q.chop;
  assign transform_clk_en    = s_q.clk_en[2];
  assign waveform_clk_en     = s_q.clk_en[1];
  assign mains_filter_clk_en = s_q.clk_en[0];

  // Checks on the block's own behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reserved_zero: assert property (s_q.rf[I_FILT][31:19] == 13'h0000)
    else $error("reserved filter bits not zero");
  a_chop_follow: assert property (##1 chop_mode == $past(s_q.rf[I_TCFG][3:1]))
    else $error("chop mode does not follow config");
  a_sensor_power: assert property (##1 temp_sensor_power == $past(s_q.rf[I_AFE][AFE_TPWR]))
    else $error("sensor power wrong");
  a_conv_begin: assert property (conv_req && !s_q.conv_q |=> conv_start ##1 !conv_start)
    else $error("conversion start pulse wrong");
  a_temp_mux: assert property (sample_in.valid && conv_active && temp_sel |=> s_q.cal_temp)
    else $error("temp channel not recognised");
  a_temp_store: assert property (s_q.cal.valid && s_q.cal_temp |=> s_q.rf[I_TEMP] == $past(s_q.cal.data))
    else $error("temp result not updated");
  a_temp_cal: assert property (temp_pos |-> off_sel == s_q.rf[I_TOFF][15:0] && gain_sel == s_q.rf[I_TGAIN][15:0])
    else $error("temp calibration not used");
  a_gate_map: assert property (##1 {transform_clk_en, waveform_clk_en, mains_filter_clk_en}
    == ~$past(s_q.rf[I_FILT][18:16]))
    else $error("clock gate mapping wrong");
  a_notch_path: assert property (mains_write |=> s_q.rf[I_MAINS] == $past(s2_next))
    else $error("mains result not written");
  a_notch_guard: assert property ($changed(s_q.rf[I_MAINS]) && !$past(s_q.bvalid == 1'b0 && s_q.aw_got)
    |-> $past(notch_on))
    else $error("mains result written with notch off");
  a_first_ratio: assert property (s_q.s1_cnt < first_ratio(first_decimation_ratio) + 3'h1)
    else $error("first stage count overrun");
  a_avg_bypass: assert property (!avg_on && s_q.cal.valid && !transform_clock_gate_n
    |=> transform_out.valid && transform_out.data == $past(s_q.cal.data))
    else $error("bypass path wrong");
  a_avg_count: assert property (avg_on |-> s_q.av_cnt < (5'h02 << average_count))
    else $error("average count overrun");
  a_bus_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");

  c_temp_write: cover property (s_q.cal.valid && s_q.cal_temp);
  c_mains_write: cover property (mains_write);
  c_avg_out: cover property (avg_on && transform_out.valid);
  c_bus_write: cover property (bvalid && bready);

endmodule

// >>> common/adc_postproc_pkg.sv
/*
  Constants, carrier types and decode functions for the ADC post-processing
  block: register offsets, field positions, reset values and timing counts.
  Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package adc_postproc_pkg;

  // Register indices
  localparam int         NREG    = 18;
  localparam logic [4:0] I_FILT  = 5'h00;
  localparam logic [4:0] I_RAW   = 5'h01;
  localparam logic [4:0] I_DRE   = 5'h02;
  localparam logic [4:0] I_DIM   = 5'h03;
  localparam logic [4:0] I_MAINS = 5'h04;
  localparam logic [4:0] I_TEMP  = 5'h05;
  localparam logic [4:0] I_DFTC  = 5'h06;
  localparam logic [4:0] I_TCFG  = 5'h07;
  localparam logic [4:0] I_ACON  = 5'h08;
  localparam logic [4:0] I_REP   = 5'h09;
  localparam logic [4:0] I_BUF   = 5'h0A;
  localparam logic [4:0] I_AFE   = 5'h0B;
  localparam logic [4:0] I_TOFF  = 5'h0C;
  localparam logic [4:0] I_TGAIN = 5'h0D;
  localparam logic [4:0] I_COFF  = 5'h0E;
  localparam logic [4:0] I_CGAIN = 5'h0F;
  localparam logic [4:0] I_PCTL  = 5'h10;
  localparam logic [4:0] I_STAT  = 5'h11;
  localparam logic [4:0] NO_REG  = 5'h1F;

  // Byte offsets
  localparam logic [15:0] OFF_FILT  = 16'h2044;
  localparam logic [15:0] OFF_RAW   = 16'h2074;
  localparam logic [15:0] OFF_DRE   = 16'h2078;
  localparam logic [15:0] OFF_DIM   = 16'h207C;
  localparam logic [15:0] OFF_MAINS = 16'h2080;
  localparam logic [15:0] OFF_TEMP  = 16'h2084;
  localparam logic [15:0] OFF_DFTC  = 16'h20D0;
  localparam logic [15:0] OFF_TCFG  = 16'h2174;
  localparam logic [15:0] OFF_ACON  = 16'h21A8;
  localparam logic [15:0] OFF_REP   = 16'h21F0;
  localparam logic [15:0] OFF_BUF   = 16'h238C;
  localparam logic [15:0] OFF_AFE   = 16'h2000;
  localparam logic [15:0] OFF_TOFF  = 16'h2300;
  localparam logic [15:0] OFF_TGAIN = 16'h2304;
  localparam logic [15:0] OFF_COFF  = 16'h2308;
  localparam logic [15:0] OFF_CGAIN = 16'h230C;
  localparam logic [15:0] OFF_PCTL  = 16'h2310;
  localparam logic [15:0] OFF_STAT  = 16'h2314;

  // Reset values and write masks
  localparam logic [31:0] RST_FILT  = 32'h0000_0301;
  localparam logic [31:0] RST_DFTC  = 32'h0000_0090;
  localparam logic [31:0] RST_REP   = 32'h0000_0160;
  localparam logic [31:0] RST_BUF   = 32'h005F_3D00;
  localparam logic [31:0] RST_GAIN  = 32'h0000_4000;
  localparam logic [31:0] MASK_FILT = 32'h0007_FFFF;

  // Field positions
  localparam int XF_GATE    = 18;
  localparam int WAVE_GATE  = 17;
  localparam int MAINS_GATE = 16;
  localparam int AVG_LSB    = 14;
  localparam int R1_LSB     = 12;
  localparam int R2_LSB     = 8;
  localparam int NOTCH_OFF  = 4;
  localparam int AFE_NOTCH  = 16;
  localparam int AFE_CONV   = 13;
  localparam int AFE_TPWR   = 12;
  localparam int AFE_ADC    = 8;
  localparam int NEG_LSB    = 8;
  localparam int CHOP_LSB   = 1;
  localparam int AVG_EN     = 0;
  localparam int CAL_SHIFT  = 14;
  localparam logic [4:0] NEG_TEMP = 5'h0B;
  localparam logic [5:0] POS_TEMP = 6'h0B;

  // Bus responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_DEC = 2'h3;

  // Mains filter settling time
  localparam int SETTLE_MS         = 37;
  localparam int CLK_KHZ           = 250000;
  localparam int SETTLE_CYCLES_DEF = SETTLE_MS * CLK_KHZ;

  // Raw converter sample and processed word carriers
  typedef struct packed {
    logic        valid;
    logic [15:0] code;
  } sample_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } word_t;

  // Whole block state
  typedef struct packed {
    logic [NREG-1:0][31:0] rf;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic                  arready;
    logic                  rvalid;
    logic [1:0]            bresp;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
    logic                  aw_got;
    logic                  w_got;
    logic [15:0]           waddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    word_t                 cal;
    logic                  cal_temp;
    logic [2:0]            s1_cnt;
    logic [31:0]           s1_acc;
    logic                  s1_done;
    logic [31:0]           s1_sum;
    logic [10:0]           s2_cnt;
    logic [31:0]           s2_acc;
    logic [4:0]            av_cnt;
    logic [31:0]           av_acc;
    word_t                 xf;
    logic                  conv_q;
    logic                  conv_start;
    logic [23:0]           settle;
    logic                  settled;
    logic                  temp_pwr;
    logic [2:0]            chop;
    logic [2:0]            clk_en;
  } state_t;

  // First stage oversampling ratio
  function automatic logic [2:0] first_ratio(input logic [1:0] c);
    case (c)
      2'h1:    return 3'h4;
      2'h2:    return 3'h2;
      default: return 3'h5;
    endcase
  endfunction

  // Second stage sample count
  function automatic logic [10:0] second_ratio(input logic [3:0] c);
    case (c)
      4'h0:    return 11'h016;
      4'h1:    return 11'h02C;
      4'h2:    return 11'h059;
      4'h3:    return 11'h0B2;
      4'h4:    return 11'h10B;
      4'h5:    return 11'h215;
      4'h6:    return 11'h280;
      4'h7:    return 11'h29B;
      4'h8:    return 11'h320;
      4'h9:    return 11'h379;
      default: return 11'h535;
    endcase
  endfunction

  // Word address to register index
  function automatic logic [4:0] reg_index(input logic [15:0] a);
    case ({a[15:2], 2'h0})
      OFF_FILT:  return I_FILT;
      OFF_RAW:   return I_RAW;
      OFF_DRE:   return I_DRE;
      OFF_DIM:   return I_DIM;
      OFF_MAINS: return I_MAINS;
      OFF_TEMP:  return I_TEMP;
      OFF_DFTC:  return I_DFTC;
      OFF_TCFG:  return I_TCFG;
      OFF_ACON:  return I_ACON;
      OFF_REP:   return I_REP;
      OFF_BUF:   return I_BUF;
      OFF_AFE:   return I_AFE;
      OFF_TOFF:  return I_TOFF;
      OFF_TGAIN: return I_TGAIN;
      OFF_COFF:  return I_COFF;
      OFF_CGAIN: return I_CGAIN;
      OFF_PCTL:  return I_PCTL;
      OFF_STAT:  return I_STAT;
      default:   return NO_REG;
    endcase
  endfunction

endpackage

// >>> test/sample_source.sv
/*
  Model of the converter front end: sends one raw sample per request,
  after a wait of 0 to 15 cycles.
  Assumes the requester holds req for one cycle and waits for done.
*/
`timescale 1ns/1ps
module sample_source
  import adc_postproc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        req,
  input  wire logic [15:0] code,
  input  wire logic [3:0]  gap,
  output sample_t          sample_out,
  output logic             done
);
  logic [3:0]  wait_q;
  logic [15:0] held_q;
  logic        busy_q;

  // Between samples the code lines toggle so no stale value passes for a new one
  always @(posedge aclk)
  begin
    done <= 1'b0;
    if (!aresetn)
    begin
      busy_q <= 1'b0;
      sample_out <= '0;
    end
    else if (sample_out.valid)
    begin
      sample_out <= {1'b0, ~sample_out.code};
      done <= 1'b1;
    end
    else if (req && !busy_q)
    begin
      busy_q <= 1'b1;
      wait_q <= gap;
      held_q <= code;
    end
    else if (busy_q && wait_q == 4'h0)
    begin
      sample_out <= {1'b1, held_q};
      busy_q <= 1'b0;
    end
    else if (busy_q)
      wait_q <= wait_q - 4'h1;
  end
endmodule

// >>> test/adc_postproc_temp_channel_bench.sv
/*
  Self-checking bench of the post-processing block: registers over AXI4-Lite,
  temperature channel, mains result, averaging and clock gates.
  Assumes the sample_source model and a short settling count.
*/
`timescale 1ns/1ps
module adc_postproc_temp_channel_bench
  import adc_postproc_pkg::*;
;
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, req = 0;
  logic [15:0] awaddr = '0, araddr = '0, code = '0;
  logic [31:0] wdata = '0, lfsr = 32'h0000_c433, s;
  logic [3:0]  wstrb = '0, gap = '0;
  logic        awready, wready, bvalid, arready, rvalid, conv_start, conv_active, temp_sensor_power, done;
  logic        transform_clk_en, waveform_clk_en, mains_filter_clk_en;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  chop_mode;
  sample_t     sample_in;
  word_t       transform_out;
  logic [33:0] rq[$], xq[$], e;
  int          miscompares = 0, num_checks = 0, starts = 0;

  adc_postproc_temp_channel #(.SETTLE_CYCLES(20)) adc_postproc_temp_channel_i (.aclk, .aresetn, .awvalid,
    .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .sample_in, .transform_out, .conv_start, .conv_active, .temp_sensor_power,
    .chop_mode, .transform_clk_en, .waveform_clk_en, .mains_filter_clk_en);
  sample_source sample_source_i (.aclk, .aresetn, .req, .code, .gap, .sample_out(sample_in), .done);

  initial forever #2 aclk = ~aclk;

  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic print_verdict();
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Register write: address and data offered together, then the response
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    `CHK(bresp, RESP_OK)
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Register read: the monitor compares against the noted value
  task automatic rd(input logic [15:0] a, input logic [33:0] x);
    rq.push_back(x);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Send n random samples; sum is of calibrated values, optionally noted for the transform
  task automatic group(input int n, input int sh, input bit push, input logic [31:0] off, output logic [31:0] t);
    logic [15:0] cs[44];
    t = '0;
    for (int i = 0; i < n; i++)
    begin
      cs[i] = {1'b0, lfsr[14:0]} | 16'h0100;
      lfsr = next_rand(lfsr);
      t = t + {16'h0, cs[i]} - off;
    end
    if (push) xq.push_back({2'h0, t >> sh});
    for (int i = 0; i < n; i++)
    begin
      code <= cs[i];
      gap <= lfsr[3:0];
      lfsr = next_rand(lfsr);
      req <= 1'b1;
      @(posedge aclk);
      req <= 1'b0;
      while (!done)
        @(posedge aclk);
    end
  endtask

  // Monitor: bus reads, transform words and start pulses
  always @(posedge aclk)
  begin
    if (conv_start) starts++;
    if (rvalid && rready)
    begin
      e = rq.size() ? rq.pop_front() : '1;
      `CHK({rresp, rdata}, e)
    end
    if (transform_out.valid)
    begin
      e = xq.size() ? xq.pop_front() : '1;
      `CHK({2'h0, transform_out.data}, e)
    end
  end

  initial
  begin
    #200000;
    miscompares++;
    print_verdict();
  end

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(16'h2044, {2'h0, 32'h0000_0301});
    rd(16'h20D0, {2'h0, 32'h0000_0090});
    rd(16'h21F0, {2'h0, 32'h0000_0160});
    rd(16'h238C, {2'h0, 32'h005F_3D00});
    rd(16'h2100, {2'h3, 32'h0000_0000});
    wr(OFF_TCFG, 32'h0000_000E);
    wr(OFF_ACON, 32'h0000_0B0B);
    wr(OFF_TOFF, 32'h0000_0010);
    wr(OFF_COFF, 32'h0000_0100);
    wr(OFF_FILT, 32'h0004_2000);
    wr(OFF_AFE, 32'h0001_3100);
    repeat (3) @(posedge aclk);
    `CHK(chop_mode, 3'h7)
    `CHK(temp_sensor_power, 1'b1)
    `CHK(conv_active, 1'b1)
    `CHK({transform_clk_en, waveform_clk_en, mains_filter_clk_en}, 3'h3)
    // Ratios 2 and 22 give one mains word per 44 samples; transform gated
    group(44, 0, 0, 32'h10, s);
    repeat (8) @(posedge aclk);
    rd(OFF_MAINS, {2'h0, s});
    rd(OFF_STAT, {2'h0, 32'h0000_000F});
    // Averaging count set but not enabled: every sample passes alone
    wr(OFF_FILT, 32'h0000_C000);
    group(1, 0, 1, 32'h10, s);
    group(1, 0, 1, 32'h10, s);
    rd(OFF_TEMP, {2'h0, s});
    wr(OFF_PCTL, 32'h0000_0001);
    for (int k = 0; k < 4; k++)
    begin
      wr(OFF_FILT, {16'h0, k[1:0], 14'h0});
      group(2 << k, k + 1, 1, 32'h10, s);
    end
    wr(OFF_PCTL, 32'h0000_0000);
    wr(OFF_ACON, 32'h0000_0B0A);
    group(1, 0, 1, 32'h100, s);
    wr(OFF_FILT, 32'hFFFF_FFFF);
    repeat (3) @(posedge aclk);
    `CHK({transform_clk_en, waveform_clk_en, mains_filter_clk_en}, 3'h0)
    rd(OFF_FILT, {2'h0, 32'h0007_FFFF});
    repeat (10) @(posedge aclk);
    `CHK(starts, 1)
    `CHK(xq.size(), 0)
    print_verdict();
  end
endmodule
